/* bench/camera_control_bus_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module camera_control_bus_asserts #(
	parameter int QUARTER_CYC = 13
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic host_scl_out,
	input wire logic host_scl_oe,
	input wire logic host_sda_out,
	input wire logic host_sda_oe,
	input wire logic dev_sda_out,
	input wire logic dev_sda_oe,
	input wire logic chip_off_n,
	input wire logic scl,
	input wire logic sda
);
	// ----
	// helper: length of one unbroken device pull on the data line
	// ----
	logic [15:0] pull_len;
	always_ff @(posedge clk) begin
		if (srst || !dev_sda_oe) begin
			pull_len <= 16'h0000;
		end else begin
			pull_len <= pull_len + 16'h0001;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	// ----
	// wire rules
	// ----
	// open drain: a driver may only pull low
	a_host_scl_od: assert property (host_scl_oe |-> !host_scl_out)
		else $error("master drives the clock line high");
	a_dev_sda_od: assert property (dev_sda_oe |-> !dev_sda_out)
		else $error("slave drives the data line high");
	// the slave moves only while the clock is low, so it can never frame a transfer
	a_dev_edge_low: assert property ($changed(dev_sda_oe) |-> !scl)
		else $error("slave changed the data line while the clock was high");
	a_start_from_host: assert property (($fell(sda) && scl && $past(scl)) |-> host_sda_oe)
		else $error("start condition not made by the master");
	a_ack_hold: assert property ((dev_sda_oe && $rose(scl)) |=> dev_sda_oe [*4])
		else $error("slave released its bit during the high phase");
	a_stop_quiet: assert property (($rose(sda) && scl && $past(scl)) |=> !dev_sda_oe [*4])
		else $error("slave pulls the data line after a stop");
	// longest legal pull: ack plus eight zero bits, with filter slack
	a_pull_bounded: assert property (pull_len < 16'(40 * QUARTER_CYC))
		else $error("slave holds the data line too long");
	a_shutdown_quiet: assert property ((!chip_off_n && !$past(chip_off_n, 8)) |-> !dev_sda_oe)
		else $error("slave active while shut down");
	a_reset_idle: assert property ($fell(srst) |-> !chip_off_n && !host_scl_oe && !dev_sda_oe)
		else $error("lines not idle after reset");
endmodule
`default_nettype wire

/* bench/camera_control_slave_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module camera_control_slave_tb_top;
	import camera_control_pkg::*;
	// short quarter keeps the run brief; the transfer waits poll done up to a bounded cycle count
	localparam int Q = 6;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic        chip_on = 1'b0;
	logic        cmd_valid = 1'b0;
	logic        bad_valid = 1'b0;
	cmd_kind_t   cmd_kind = CMD_WRITE;
	logic [15:0] cmd_index = 16'h0000;
	logic [7:0]  cmd_len = 8'h01;
	logic [7:0]  wq [4];
	logic [1:0]  wp = 2'h0;
	logic [7:0]  mem [256];
	logic [7:0]  rq [$];
	logic [15:0] widx [$];
	logic [15:0] rd_idx [$];
	logic [7:0]  m_rd_data, s_wr_data, addr_seen;
	logic [15:0] s_index;
	logic [3:0]  nbits = 4'h0;
	logic        cmd_ready, wr_take, rd_valid, done, nack_err, s_wr_strobe, powered_up;
	logic        bad_ready, bad_done, bad_nack, scl_d, sda_d, s_rd_strobe;
	int          mismatches = 0;
	int          checked = 0;

	camera_control_bus_if bus ();
	camera_control_bus_if bad_bus ();

	always #25 clk = ~clk;

	camera_control_master #(.QUARTER_CYC(Q)) u_camera_control_master (
		.clk(clk), .srst(srst), .bus(bus.host), .chip_on(chip_on), .cmd_valid(cmd_valid),
		.cmd_kind(cmd_kind), .cmd_index(cmd_index), .cmd_len(cmd_len), .wr_data(wq[wp]),
		.cmd_ready(cmd_ready), .wr_take(wr_take), .rd_data(m_rd_data), .rd_valid(rd_valid),
		.done(done), .nack_err(nack_err));
	camera_control_slave u_camera_control_slave (
		.clk(clk), .srst(srst), .bus(bus.device), .index(s_index), .wr_data(s_wr_data),
		.wr_strobe(s_wr_strobe), .rd_data(mem[s_index[7:0]]), .rd_strobe(s_rd_strobe),
		.powered_up(powered_up));
	// second pair: the slave answers another address, so the master must be refused
	camera_control_master #(.QUARTER_CYC(Q)) u_camera_control_master_bad (
		.clk(clk), .srst(srst), .bus(bad_bus.host), .chip_on(chip_on), .cmd_valid(bad_valid),
		.cmd_kind(cmd_kind), .cmd_index(cmd_index), .cmd_len(cmd_len), .wr_data(wq[0]),
		.cmd_ready(bad_ready), .wr_take(), .rd_data(), .rd_valid(), .done(bad_done),
		.nack_err(bad_nack));
	camera_control_slave #(.DEVICE_ADDR(7'h11)) u_camera_control_slave_bad (
		.clk(clk), .srst(srst), .bus(bad_bus.device), .index(), .wr_data(), .wr_strobe(),
		.rd_data(8'h00), .rd_strobe(), .powered_up());
	camera_control_bus_asserts #(.QUARTER_CYC(Q)) u_camera_control_bus_asserts (
		.clk(clk), .srst(srst), .host_scl_out(bus.host_scl_out), .host_scl_oe(bus.host_scl_oe),
		.host_sda_out(bus.host_sda_out), .host_sda_oe(bus.host_sda_oe),
		.dev_sda_out(bus.dev_sda_out), .dev_sda_oe(bus.dev_sda_oe),
		.chip_off_n(bus.chip_off_n), .scl(bus.scl), .sda(bus.sda));

	// ----
	// wire monitor and register-space model
	// ----
	// first byte after any start, repeated ones included
	always @(posedge clk) begin
		scl_d <= bus.scl;
		sda_d <= bus.sda;
		if (scl_d && bus.scl && sda_d && !bus.sda) begin
			nbits <= 4'h0;
		end else if (!scl_d && bus.scl && nbits != 4'hF) begin
			nbits <= nbits + 4'h1;
			if (nbits < 4'h8) addr_seen <= {addr_seen[6:0], bus.sda};
		end
		if (rd_valid) rq.push_back(m_rd_data);
		if (s_rd_strobe) rd_idx.push_back(s_index);
		if (s_wr_strobe) begin
			widx.push_back(s_index);
			mem[s_index[7:0]] <= s_wr_data;
		end
		if (cmd_valid && cmd_ready) wp <= 2'h0;
		else if (wr_take) wp <= wp + 2'h1;
	end

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one command, held for one edge; waits stay bounded
	task automatic xfer(input bit bad, input cmd_kind_t k, input logic [15:0] i,
		input logic [7:0] n);
		int t;
		t = 0;
		while ((bad ? bad_ready : cmd_ready) !== 1'b1 && t < 50) begin
			@(negedge clk);
			t++;
		end
		rq.delete();
		widx.delete();
		rd_idx.delete();
		cmd_kind = k;
		cmd_index = i;
		cmd_len = n;
		if (bad) bad_valid = 1'b1;
		else cmd_valid = 1'b1;
		@(negedge clk);
		cmd_valid = 1'b0;
		bad_valid = 1'b0;
		t = 0;
		while ((bad ? bad_done : done) !== 1'b1 && t < 4000) begin
			@(negedge clk);
			t++;
		end
		check("done", 16'(bad ? bad_done : done), 16'h0001);
		// look at the pair that just ran, not always the good one
		check("idle lines", bad ? {14'h0, bad_bus.scl, bad_bus.sda}
			: {14'h0, bus.scl, bus.sda}, 16'h0003);
	endtask

	task automatic got(input int n, input logic [7:0] e0, input logic [7:0] e1);
		check("read count", 16'(rq.size()), 16'(n));
		check("read strobes", 16'(rd_idx.size()), 16'(n));
		check("read byte 0", {8'h00, rq[0]}, {8'h00, e0});
		if (n > 1) check("read byte 1", {8'h00, rq[1]}, {8'h00, e1});
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// ----
	// scenarios
	// ----
	initial begin
		for (int a = 0; a < 256; a++) mem[a] = 8'(a) ^ 8'hA5;
		wq[0] = 8'h11;
		wq[1] = 8'h22;
		wq[2] = 8'h33;
		wq[3] = 8'h00;
		repeat (6) @(negedge clk);
		srst = 1'b0;
		@(negedge clk);
		check("powered_up", 16'(powered_up), 16'h0000);
		chip_on = 1'b1;
		repeat (12) @(negedge clk);
		check("powered_up", 16'(powered_up), 16'h0001);
		xfer(1'b0, CMD_READ_CUR, 16'h0000, 8'h02);
		got(2, 8'hA5, 8'hA4);
		check("addr byte", 16'(addr_seen), 16'(ADDR_BYTE_RD));
		check("index", s_index, 16'h0002);
		// sequential write whose index carries into the high byte
		xfer(1'b0, CMD_WRITE, 16'h12FE, 8'h03);
		check("addr byte", 16'(addr_seen), 16'(ADDR_BYTE_WR));
		check("writes", 16'(widx.size()), 16'h0003);
		for (int j = 0; j < 3; j++) check("write index", widx[j], 16'h12FE + 16'(j));
		check("index", s_index, 16'h1301);
		check("nack_err", 16'(nack_err), 16'h0000);
		xfer(1'b0, CMD_READ_NEW, 16'h12FE, 8'h02);
		got(2, 8'h11, 8'h22);
		check("addr byte", 16'(addr_seen), 16'(ADDR_BYTE_RD));
		xfer(1'b0, CMD_READ_CUR, 16'h0000, 8'h01);
		got(1, 8'h33, 8'h00);
		// a length of zero still moves one byte
		wq[0] = 8'h44;
		xfer(1'b0, CMD_WRITE, 16'h00AB, 8'h00);
		check("writes", 16'(widx.size()), 16'h0001);
		xfer(1'b0, CMD_READ_NEW, 16'h00AB, 8'h01);
		got(1, 8'h44, 8'h00);
		xfer(1'b1, CMD_WRITE, 16'h0010, 8'h01);
		check("refused", 16'(bad_nack), 16'h0001);
		// shutdown returns the index to zero
		chip_on = 1'b0;
		repeat (10) @(negedge clk);
		check("powered_up", 16'(powered_up), 16'h0000);
		check("index", s_index, 16'h0000);
		chip_on = 1'b1;
		repeat (12) @(negedge clk);
		xfer(1'b0, CMD_READ_CUR, 16'h0000, 8'h01);
		// the model keeps only the low index byte, so 0x1300 landed at 0x00
		got(1, 8'h33, 8'h00);
		tally_and_finish();
	end

	// hang guard, well beyond the expected run length
	initial begin
		repeat (40000) @(posedge clk);
		mismatches++;
		tally_and_finish();
	end
endmodule
`default_nettype wire

/* verilog/camera_control_bus_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface camera_control_bus_if;
	logic host_scl_out;
	logic host_scl_oe;
	logic host_sda_out;
	logic host_sda_oe;
	logic dev_sda_out;
	logic dev_sda_oe;
	logic chip_off_n;
	logic scl;
	logic sda;

	// open-drain wired-and: a line is low while any enabled driver pulls it
	assign scl = host_scl_oe ? host_scl_out : 1'b1;
	assign sda = (host_sda_oe ? host_sda_out : 1'b1) & (dev_sda_oe ? dev_sda_out : 1'b1);

	modport host (
		output host_scl_out,
		output host_scl_oe,
		output host_sda_out,
		output host_sda_oe,
		output chip_off_n,
		input  scl,
		input  sda
	);

	modport device (
		output dev_sda_out,
		output dev_sda_oe,
		input  chip_off_n,
		input  scl,
		input  sda
	);
endinterface
`default_nettype wire

/* verilog/camera_control_master.sv */
`timescale 1ns/1ps
`default_nettype none
module camera_control_master
	import camera_control_pkg::*;
#(
	parameter int QUARTER_CYC = SCL_QUARTER_CYC
) (
	input  wire logic         clk,
	input  wire logic         srst,
	camera_control_bus_if.host bus,
	input  wire logic         chip_on,
	input  wire logic         cmd_valid,
	input  wire cmd_kind_t    cmd_kind,
	input  wire logic [15:0]  cmd_index,
	input  wire logic [7:0]   cmd_len,
	input  wire logic [7:0]   wr_data,
	output logic              cmd_ready,
	output logic              wr_take,
	output logic [7:0]        rd_data,
	output logic              rd_valid,
	output logic              done,
	output logic              nack_err
);

	// quarter must outlast the synchroniser delay and fit the 8-bit counter
	if (QUARTER_CYC < 4 || QUARTER_CYC > 255) begin : g_bad_quarter
		$error("QUARTER_CYC out of range");
	end

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		H_IDLE  = 2'b00,
		H_START = 2'b01,
		H_BIT   = 2'b10,
		H_STOP  = 2'b11
	} host_state_t;

	typedef enum logic [2:0] {
		P_ADDRW = 3'b000,
		P_IDXH  = 3'b001,
		P_IDXL  = 3'b010,
		P_WDATA = 3'b011,
		P_ADDRR = 3'b100,
		P_RDATA = 3'b101
	} host_phase_t;

	typedef struct packed {
		logic [SYNC_STAGES-1:0] scl_sy;
		logic [SYNC_STAGES-1:0] sda_sy;
		logic        scl_f;
		logic        sda_f;
		logic [7:0]  cnt;
		host_state_t st;
		host_phase_t phase;
		cmd_kind_t   kind;
		logic [1:0]  q;
		logic [3:0]  bitn;
		logic [7:0]  sh;
		logic [7:0]  rx;
		logic        ackbit;
		logic [7:0]  left;
		logic [15:0] index;
		logic        scl_oe;
		logic        sda_oe;
		logic        chip_off_n;
		logic        cmd_ready;
		logic        wr_take;
		logic [7:0]  rd_data;
		logic        rd_valid;
		logic        done;
		logic        nack_err;
	} host_regs_t;

	host_regs_t s;
	host_regs_t next_s;
	logic       tick;

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.wr_take    = 1'b0;
		next_s.rd_valid   = 1'b0;
		next_s.done       = 1'b0;
		next_s.chip_off_n = chip_on; // R12
		next_s.scl_sy     = {s.scl_sy[1:0], bus.scl};
		next_s.sda_sy     = {s.sda_sy[1:0], bus.sda};
		if (s.scl_sy[1] == s.scl_sy[2]) begin
			next_s.scl_f = s.scl_sy[2];
		end
		if (s.sda_sy[1] == s.sda_sy[2]) begin
			next_s.sda_f = s.sda_sy[2];
		end
		tick = (s.cnt == 8'(QUARTER_CYC - 1));
		next_s.cnt = (tick || s.st == H_IDLE) ? 8'h00 : s.cnt + 8'h01;

		case (s.st)
			H_IDLE: begin
				if (cmd_valid && s.cmd_ready) begin
					next_s.cmd_ready = 1'b0;
					next_s.nack_err  = 1'b0;
					next_s.kind      = cmd_kind;
					next_s.index     = cmd_index;
					next_s.left      = (cmd_len == 8'h00) ? 8'h01 : cmd_len;
					next_s.phase     = (cmd_kind == CMD_READ_CUR) ? P_ADDRR : P_ADDRW; // R09
					next_s.st        = H_START; // R02
					next_s.q         = 2'h0;
				end
			end
			H_START: begin
				// also serves as repeated start from a low clock
				if (tick) begin
					next_s.q = s.q + 2'h1;
					case (s.q)
						2'h0: next_s.sda_oe = 1'b0;
						2'h1: next_s.scl_oe = 1'b0;
						2'h2: next_s.sda_oe = 1'b1;
						default: begin
							next_s.scl_oe = 1'b1;
							next_s.st     = H_BIT;
							next_s.bitn   = 4'h0;
							next_s.sh     = (s.phase == P_ADDRR) ? ADDR_BYTE_RD : ADDR_BYTE_WR;
						end
					endcase
				end
			end
			H_BIT: begin
				// waiting for a high clock in quarter two keeps a stretched bit safe
				if (tick && !(s.q == 2'h2 && !s.scl_f)) begin
					next_s.q = s.q + 2'h1;
					case (s.q)
						2'h0: begin
							if (s.bitn != 4'h8) begin
								next_s.sda_oe = ~s.sh[7];
							end else begin
								next_s.sda_oe = (s.phase == P_RDATA) && (s.left != 8'h01); // R08
							end
						end
						2'h1: next_s.scl_oe = 1'b0;
						2'h2: begin
							if (s.bitn != 4'h8) begin
								next_s.rx = {s.rx[6:0], s.sda_f};
							end else begin
								next_s.ackbit = s.sda_f;
							end
						end
						default: begin
							next_s.scl_oe = 1'b1;
							next_s.bitn   = s.bitn + 4'h1;
							next_s.sh     = {s.sh[6:0], 1'b1};
							if (s.bitn == 4'h8) begin
								next_s.bitn = 4'h0;
								next_s.sh   = 8'hFF;
								if (s.phase == P_RDATA) begin
									next_s.rd_data  = s.rx;
									next_s.rd_valid = 1'b1;
									next_s.left     = s.left - 8'h01;
									if (s.left == 8'h01) begin
										next_s.st = H_STOP;
									end
								end else if (s.ackbit) begin
									next_s.nack_err = 1'b1;
									next_s.st       = H_STOP;
								end else begin
									case (s.phase)
										P_ADDRW: begin
											next_s.phase = P_IDXH; // R05
											next_s.sh    = s.index[15:8];
										end
										P_IDXH: begin
											next_s.phase = P_IDXL;
											next_s.sh    = s.index[7:0];
										end
										P_IDXL: begin
											if (s.kind == CMD_WRITE) begin
												next_s.phase   = P_WDATA; // R10
												next_s.sh      = wr_data;
												next_s.wr_take = 1'b1;
											end else begin
												next_s.phase = P_ADDRR; // R13
												next_s.st    = H_START;
												next_s.q     = 2'h0;
											end
										end
										P_WDATA: begin
											next_s.left = s.left - 8'h01;
											if (s.left == 8'h01) begin
												next_s.st = H_STOP;
											end else begin
												next_s.sh      = wr_data;
												next_s.wr_take = 1'b1;
											end
										end
										default: next_s.phase = P_RDATA;
									endcase
								end
							end
						end
					endcase
				end
			end
			default: begin
				if (tick) begin
					next_s.q = s.q + 2'h1;
					case (s.q)
						2'h0: next_s.sda_oe = 1'b1;
						2'h1: next_s.scl_oe = 1'b0;
						2'h2: next_s.sda_oe = 1'b0;
						default: begin
							next_s.st        = H_IDLE; // R07
							next_s.done      = 1'b1;
							next_s.cmd_ready = 1'b1;
						end
					endcase
				end
			end
		endcase
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			// released lines read high, so the filters start at the idle level
			s           <= '0;
			s.scl_sy    <= '1;
			s.sda_sy    <= '1;
			s.scl_f     <= 1'b1;
			s.sda_f     <= 1'b1;
			s.cmd_ready <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// sole master, open drain on both lines
	assign bus.host_scl_out = 1'b0; // R03
	assign bus.host_scl_oe  = s.scl_oe;
	assign bus.host_sda_out = 1'b0; // R04
	assign bus.host_sda_oe  = s.sda_oe;
	assign bus.chip_off_n   = s.chip_off_n;
	assign cmd_ready        = s.cmd_ready;
	assign wr_take          = s.wr_take;
	assign rd_data          = s.rd_data;
	assign rd_valid         = s.rd_valid;
	assign done             = s.done;
	assign nack_err         = s.nack_err;

endmodule
`default_nettype wire

/* verilog/camera_control_pkg.sv */
package camera_control_pkg;

	// ----------------------------------------------------------------
	// addressing
	// ----------------------------------------------------------------
	localparam logic [6:0] SLAVE_ADDR     = 7'h10;
	localparam logic [7:0] ADDR_BYTE_WR   = 8'h20;
	localparam logic [7:0] ADDR_BYTE_RD   = 8'h21;
	localparam logic [15:0] INDEX_RESET   = 16'h0000;

	// ----------------------------------------------------------------
	// timing: one serial clock quarter at fast-mode rate
	// ----------------------------------------------------------------
	localparam int CLK_FREQ_MHZ    = 20;
	localparam int SCL_QUARTER_NS  = 625;
	// least time, so round up to whole cycles
	localparam int SCL_QUARTER_CYC = (SCL_QUARTER_NS * CLK_FREQ_MHZ + 999) / 1000;
	localparam int SYNC_STAGES     = 3;

	// ----------------------------------------------------------------
	// host command kinds
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CMD_WRITE    = 2'b00,
		CMD_READ_NEW = 2'b01,
		CMD_READ_CUR = 2'b10
	} cmd_kind_t;

endpackage

/* verilog/camera_control_slave.sv */
// Overview of operation
// R01 - slave follows fast-mode two-wire framing
// R02 - host masters, sensor never starts transfers
// R03 - single master, several slaves allowed
// R04 - master uses only mandatory slave features
// R05 - sixteen-bit index in two bytes, byte data
// R06 - answer address 0x10, write 0x20, read 0x21
// R07 - start/stop framing, acknowledge every received byte
// R08 - return bytes until master not-acknowledges
// R09 - four read forms, new or current index
// R10 - single and sequential writes at index
// R11 - index increments after every data byte
// R12 - host holds shutdown low to power off
// R13 - new-index read: write index, repeated start
`timescale 1ns/1ps
`default_nettype none
module camera_control_slave
	import camera_control_pkg::*;
#(
	parameter logic [6:0] DEVICE_ADDR = SLAVE_ADDR
) (
	input  wire logic         clk,
	input  wire logic         srst,
	camera_control_bus_if.device bus,
	output logic [15:0]       index,
	output logic [7:0]        wr_data,
	output logic              wr_strobe,
	input  wire logic [7:0]   rd_data,
	output logic              rd_strobe,
	output logic              powered_up
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		D_IDLE   = 3'b000,
		D_RX     = 3'b001,
		D_RX_ACK = 3'b010,
		D_TX     = 3'b011,
		D_TX_ACK = 3'b100
	} dev_state_t;

	typedef enum logic [1:0] {
		PH_ADDR   = 2'b00,
		PH_IDX_HI = 2'b01,
		PH_IDX_LO = 2'b10,
		PH_DATA   = 2'b11
	} dev_phase_t;

	typedef struct packed {
		logic [SYNC_STAGES-1:0] scl_sy;
		logic [SYNC_STAGES-1:0] sda_sy;
		logic [SYNC_STAGES-1:0] on_sy;
		logic                   scl_f;
		logic                   sda_f;
		logic                   on_f;
		dev_state_t             st;
		dev_phase_t             phase;
		logic                   rw;
		logic [2:0]             bitn;
		logic                   got;
		logic                   bump;
		logic [7:0]             sh;
		logic [15:0]            index;
		logic [7:0]             wr_data;
		logic                   wr_strobe;
		logic                   rd_strobe;
		logic                   sda_oe;
	} dev_regs_t;

	dev_regs_t s;
	dev_regs_t next_s;
	logic      rise;
	logic      fall;
	logic      start_seen;
	logic      stop_seen;

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.wr_strobe = 1'b0;
		next_s.rd_strobe = 1'b0;

		// three-stage synchronisers; a level counts once stages two and three agree
		next_s.scl_sy = {s.scl_sy[1:0], bus.scl};
		next_s.sda_sy = {s.sda_sy[1:0], bus.sda};
		next_s.on_sy  = {s.on_sy[1:0], bus.chip_off_n};
		if (s.scl_sy[1] == s.scl_sy[2]) begin
			next_s.scl_f = s.scl_sy[2];
		end
		if (s.sda_sy[1] == s.sda_sy[2]) begin
			next_s.sda_f = s.sda_sy[2];
		end
		if (s.on_sy[1] == s.on_sy[2]) begin
			next_s.on_f = s.on_sy[2];
		end

		// line events on filtered levels; start and stop only while clock is high
		rise       = next_s.scl_f & ~s.scl_f;
		fall       = ~next_s.scl_f & s.scl_f;
		start_seen = next_s.scl_f & s.scl_f & s.sda_f & ~next_s.sda_f; // R07
		stop_seen  = next_s.scl_f & s.scl_f & ~s.sda_f & next_s.sda_f; // R07

		if (!next_s.on_f) begin
			// shut down: protocol state and index cleared, data line released
			next_s.st     = D_IDLE;
			next_s.sda_oe = 1'b0;
			next_s.index  = INDEX_RESET;
			next_s.got    = 1'b0;
			next_s.bump   = 1'b0;
		end else if (start_seen) begin
			// a repeated start keeps the index, so current-location reads work
			next_s.st     = D_RX; // R09
			next_s.phase  = PH_ADDR;
			next_s.bitn   = 3'h0;
			next_s.got    = 1'b0;
			next_s.bump   = 1'b0;
			next_s.sda_oe = 1'b0;
		end else if (stop_seen) begin
			next_s.st     = D_IDLE; // R07
			next_s.sda_oe = 1'b0;
		end else begin
			case (s.st)
				D_RX: begin
					if (rise) begin
						next_s.sh   = {s.sh[6:0], s.sda_f};
						next_s.bitn = s.bitn + 3'h1;
						next_s.got  = (s.bitn == 3'h7);
					end else if (fall && s.got) begin
						next_s.got    = 1'b0;
						next_s.sda_oe = 1'b1; // R07
						next_s.st     = D_RX_ACK;
						case (s.phase)
							PH_ADDR: begin
								// a foreign address is ignored until the next start
								if (s.sh[7:1] == DEVICE_ADDR) begin // R06
									next_s.rw    = s.sh[0];
									next_s.phase = PH_IDX_HI;
								end else begin
									next_s.sda_oe = 1'b0;
									next_s.st     = D_IDLE;
								end
							end
							PH_IDX_HI: begin
								next_s.index[15:8] = s.sh; // R05
								next_s.phase       = PH_IDX_LO;
							end
							PH_IDX_LO: begin
								next_s.index[7:0] = s.sh; // R05
								next_s.phase      = PH_DATA;
							end
							default: begin
								next_s.wr_data   = s.sh; // R10
								next_s.wr_strobe = 1'b1;
								next_s.bump      = 1'b1;
							end
						endcase
					end
				end
				D_RX_ACK: begin
					if (fall) begin
						next_s.sda_oe = 1'b0;
						next_s.bitn   = 3'h0;
						next_s.bump   = 1'b0;
						// step after the write strobe so the user saw the old index
						if (s.bump) begin
							next_s.index = s.index + 16'h0001; // R11
						end
						if (s.rw) begin
							next_s.st        = D_TX; // R09
							next_s.sh        = rd_data;
							next_s.sda_oe    = ~rd_data[7];
							next_s.rd_strobe = 1'b1;
						end else begin
							next_s.st = D_RX;
						end
					end
				end
				D_TX: begin
					if (fall) begin
						next_s.bitn = s.bitn + 3'h1;
						if (s.bitn == 3'h7) begin
							next_s.st     = D_TX_ACK;
							next_s.sda_oe = 1'b0;
							next_s.index  = s.index + 16'h0001; // R11
						end else begin
							next_s.sh     = {s.sh[6:0], 1'b0};
							next_s.sda_oe = ~s.sh[6];
						end
					end
				end
				D_TX_ACK: begin
					if (rise) begin
						// not-acknowledge ends the read with the line released
						if (s.sda_f) begin
							next_s.st = D_IDLE; // R08
						end else begin
							next_s.got = 1'b1;
						end
					end else if (fall && s.got) begin
						next_s.got       = 1'b0;
						next_s.st        = D_TX; // R08
						next_s.bitn      = 3'h0;
						next_s.sh        = rd_data;
						next_s.sda_oe    = ~rd_data[7];
						next_s.rd_strobe = 1'b1;
					end
				end
				default: begin
					next_s.sda_oe = 1'b0; // R02
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			// released lines read high, so no false edge follows reset
			s        <= '0;
			s.scl_sy <= '1;
			s.sda_sy <= '1;
			s.scl_f  <= 1'b1;
			s.sda_f  <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// open drain: the device only ever pulls low
	assign bus.dev_sda_out = 1'b0; // R01
	assign bus.dev_sda_oe  = s.sda_oe;
	assign index           = s.index;
	assign wr_data         = s.wr_data;
	assign wr_strobe       = s.wr_strobe;
	assign rd_strobe       = s.rd_strobe;
	assign powered_up      = s.on_f;

endmodule
`default_nettype wire
